// [verilog/rcl_defs.svh]
/*
  Constants of the regulator control logic: timing, offsets, fields and resets.
  Assumes a 25 MHz system clock and 32-bit registers on byte addresses.
*/
`ifndef RCL_DEFS_SVH
`define RCL_DEFS_SVH

// ********************
// timing
// ********************
`define RCL_CLK_MHZ   25
`define RCL_MEAS_US   50
`define RCL_MEAS_CYC  (`RCL_MEAS_US * `RCL_CLK_MHZ)
`define RCL_WIN_US    10
`define RCL_WIN_CYC   (`RCL_WIN_US * `RCL_CLK_MHZ)
`define RCL_BOOT_US   1200
`define RCL_BOOT_CYC  (`RCL_BOOT_US * `RCL_CLK_MHZ)
`define RCL_STEP_US   1000
`define RCL_STEP_CYC  (`RCL_STEP_US * `RCL_CLK_MHZ)
`define RCL_PWM_MA    600
`define RCL_LSB_MA    20
`define RCL_PWM_CODE  (`RCL_PWM_MA / `RCL_LSB_MA)

// ********************
// register byte offsets
// ********************
`define RCL_OFS_CTRL   6'h00
`define RCL_OFS_DELAY  6'h04
`define RCL_OFS_MSEL   6'h08
`define RCL_OFS_RESLO  6'h0c
`define RCL_OFS_RESHI  6'h10
`define RCL_OFS_FLAGS  6'h14
`define RCL_OFS_MASK   6'h18
`define RCL_OFS_STATUS 6'h1c
`define RCL_OFS_FREQ   6'h20

// ********************
// fields and resets
// ********************
`define RCL_CTRL_ON    0
`define RCL_CTRL_PIN   4
`define RCL_CTRL_FPWM  8
`define RCL_CTRL_DITH  10
`define RCL_CTRL_PLL   11
`define RCL_CTRL_RST   12'h000
`define RCL_DELAY_RST  32'h0000_0000
`define RCL_MASK_RST   2'h0
`define RCL_FREQ_RST   5'h00

`endif

// [verilog/rcl_pkg.sv]
/*
  Types of the regulator control logic.
  Assumes nothing beyond the constants header.
*/
package rcl_pkg;
  typedef enum logic [1:0] {
    ST_BOOT    = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ACTIVE  = 2'b10
  } rcl_state_t;
endpackage

// [verilog/rcl_clkdet.sv]
/*
  Sync clock detector: counts input edges in a fixed window and checks the
  count against the programmed nominal frequency. Edge pulses come synchronised.
*/
`timescale 1ns/1ps
`include "rcl_defs.svh"

module rcl_clkdet (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic       rise,
  input  wire logic [4:0] freq,
  output logic            valid_ff
);
  logic [7:0] win_ff;
  logic [8:0] cnt_ff;
  logic [8:0] mhz;
  logic [8:0] lo;
  logic [8:0] hi;

  // code n means n+1 MHz; window of 10 us gives 10 edges per MHz
  assign mhz = {4'h0, freq} + 9'h001;
  assign lo  = 9'(mhz * 9'h007);
  assign hi  = 9'(mhz * 9'h00b);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_ff   <= 8'h00;
      cnt_ff   <= 9'h000;
      valid_ff <= 1'b0;
    end else if (!en) begin
      win_ff   <= 8'h00;
      cnt_ff   <= 9'h000;
      valid_ff <= 1'b0;
    end else if (win_ff == 8'(`RCL_WIN_CYC - 1)) begin
      win_ff   <= 8'h00;
      cnt_ff   <= {8'h00, rise};
      valid_ff <= (cnt_ff >= lo) && (cnt_ff <= hi);
    end else begin
      win_ff <= 8'(win_ff + 8'h01);
      if (rise && cnt_ff != 9'h1ff) begin
        cnt_ff <= 9'(cnt_ff + 9'h001);
      end
    end
  end

  a_det_off: assert property (@(posedge clk) disable iff (rst)
    !en |=> !valid_ff) else $error("detector valid while disabled");
endmodule

// [verilog/rcl_seqtimer.sv]
/*
  Start-up and shutdown delay timer of one regulator, plus its enable decision.
  Assumes synchronised enable pin edges and a shared delay step tick.
*/
`timescale 1ns/1ps
`include "rcl_defs.svh"

module rcl_seqtimer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       pin_rise,
  input  wire logic       pin_fall,
  input  wire logic [3:0] rise_dly,
  input  wire logic [3:0] fall_dly,
  input  wire logic       on_bit,
  input  wire logic       pin_sel,
  input  wire logic       allowed,
  output logic            on_ff
);
  logic       pin_st_ff;
  logic       busy_ff;
  logic       tgt_ff;
  logic [3:0] left_ff;

  // ********************
  // delay timer
  // ********************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_st_ff <= 1'b0;
      busy_ff   <= 1'b0;
      tgt_ff    <= 1'b0;
      left_ff   <= 4'h0;
    end else if (pin_rise || pin_fall) begin
      // a new edge restarts the wait in its own direction
      tgt_ff  <= pin_rise;
      left_ff <= pin_rise ? rise_dly : fall_dly;
      busy_ff <= (pin_rise ? rise_dly : fall_dly) != 4'h0;
      if ((pin_rise ? rise_dly : fall_dly) == 4'h0) begin
        pin_st_ff <= pin_rise;
      end
    end else if (busy_ff && tick) begin
      left_ff <= 4'(left_ff - 4'h1);
      if (left_ff == 4'h1) begin
        busy_ff   <= 1'b0;
        pin_st_ff <= tgt_ff;
      end
    end
  end

  // register writes act at once, only pin edges are delayed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_ff <= 1'b0;
    end else begin
      on_ff <= allowed && on_bit && (!pin_sel || pin_st_ff);
    end
  end

  a_off_bit: assert property (@(posedge clk) disable iff (rst)
    !on_bit |=> !on_ff) else $error("regulator on with enable bit low");
  a_reg_direct: assert property (@(posedge clk) disable iff (rst)
    allowed && on_bit && !pin_sel |=> on_ff) else $error("register enable delayed");
endmodule

// [verilog/rcl_top.sv]
/*
  Regulator control logic: enables with pin delays, buck PWM/PFM choice,
  load current measurement, spread spectrum gating, sync clock detection.
  Assumes an Avalon-MM master on the same clock and asynchronous pins
  (enable, sync clock, load current codes) that are synchronised here.
*/
//
// Contract
// - auto mode: PWM at 600 mA up, else PFM
// - forced PWM keeps buck in PWM always
// - select write picks buck, starts measurement
// - measured buck forced PWM, done within 50 us
// - done sets flag; interrupt unless masked
// - result split: low byte, then bit 8
// - result counts 20 mA per step
// - dither only with enable bit, PLL off
// - PLL on: detect clock, flag changes, switch
// - sync mask hides interrupt, flag still set
// - 5-bit nominal frequency, 1 to 32 MHz
// - clock valid within minus 30, plus 10 percent
// - missing clock flagged at standby and active entry; standby entry flagged only from boot, not from active
// - after boot enter standby with defaults
// - enables accepted in standby or active
// - buck: bit alone, or pin under pin select
// - linear: bit alone, or pin under pin select
// - pin rise waits own start-up delay
// - pin fall waits own shutdown delay
// - register enables act without delay
// - enable bit low forces regulator off
`timescale 1ns/1ps
`include "rcl_defs.svh"

module rcl_top
  import rcl_pkg::*;
#(
  parameter int BOOT_CYCLES = `RCL_BOOT_CYC,
  parameter int STEP_CYCLES = `RCL_STEP_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        EN_PIN,
  input  wire logic        SYNC_CLOCK_INPUT,
  input  wire logic [8:0]  LOAD_CODE0,
  input  wire logic [8:0]  LOAD_CODE1,
  output logic      [3:0]  REG_ON,
  output logic      [1:0]  BUCK_PWM,
  output logic             DITHER_ACTIVE,
  output logic             CLK_EXT_SEL,
  output logic             IRQ
);
  localparam int A_MEAS_MAX = `RCL_MEAS_CYC;

  rcl_state_t  state_ff;
  logic [14:0] boot_ff;
  logic [14:0] step_ff;
  logic        tick_ff;
  logic [11:0] ctrl_ff;
  logic [31:0] delay_ff;
  logic        msel_ff;
  logic [8:0]  result_ff;
  logic [1:0]  flag_ff;
  logic [1:0]  mask_ff;
  logic [4:0]  freq_ff;
  logic        meas_busy_ff;
  logic [10:0] meas_cnt_ff;
  logic        valid_d_ff;
  logic        valid;
  logic [3:0]  on_w;
  logic [1:0]  set_w;
  logic [1:0]  clr_w;
  logic        take;
  logic        wr_take;
  logic [31:0] rd_w;
  logic [31:0] ctrl_m;
  logic [31:0] delay_m;
  logic [31:0] mask_m;
  logic [31:0] freq_m;
  logic [1:0]  en_s_ff;
  logic        en_d_ff;
  logic [1:0]  sc_s_ff;
  logic        sc_d_ff;
  logic [8:0]  ld0_s1_ff;
  logic [8:0]  ld0_s2_ff;
  logic [8:0]  ld1_s1_ff;
  logic [8:0]  ld1_s2_ff;
  logic        pll_en;
  logic        det_en;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  // ********************
  // pin synchronisers
  // ********************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      en_s_ff   <= 2'h0;
      en_d_ff   <= 1'b0;
      sc_s_ff   <= 2'h0;
      sc_d_ff   <= 1'b0;
      ld0_s1_ff <= 9'h000;
      ld0_s2_ff <= 9'h000;
      ld1_s1_ff <= 9'h000;
      ld1_s2_ff <= 9'h000;
    end else begin
      en_s_ff   <= {en_s_ff[0], EN_PIN};
      en_d_ff   <= en_s_ff[1];
      sc_s_ff   <= {sc_s_ff[0], SYNC_CLOCK_INPUT};
      sc_d_ff   <= sc_s_ff[1];
      // codes change slowly; a torn sample only lasts one cycle
      ld0_s1_ff <= LOAD_CODE0;
      ld0_s2_ff <= ld0_s1_ff;
      ld1_s1_ff <= LOAD_CODE1;
      ld1_s2_ff <= ld1_s1_ff;
    end
  end

  // ********************
  // boot and device state
  // ********************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_BOOT;
      boot_ff  <= 15'h0000;
    end else begin
      unique case (state_ff)
        ST_BOOT: begin
          // host keeps off the bus for this long
          boot_ff <= 15'(boot_ff + 15'h0001);
          if (boot_ff == 15'(BOOT_CYCLES - 1)) state_ff <= ST_STANDBY;
        end
        ST_STANDBY: begin
          if (on_w[1:0] != 2'h0) state_ff <= ST_ACTIVE;
        end
        ST_ACTIVE: begin
          if (on_w[1:0] == 2'h0) state_ff <= ST_STANDBY;
        end
        default: state_ff <= ST_BOOT;
      endcase
    end
  end

  // ********************
  // delay step divider
  // ********************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      step_ff <= 15'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (step_ff == 15'(STEP_CYCLES - 1));
      step_ff <= (step_ff == 15'(STEP_CYCLES - 1)) ? 15'h0000 : 15'(step_ff + 15'h0001);
    end
  end

  // ********************
  // regulator enables
  // ********************
  for (genvar i = 0; i < 4; i++) begin : g_reg
    rcl_seqtimer rcl_seqtimer_i (
      .clk      (CLOCK),
      .rst      (RST),
      .tick     (tick_ff),
      .pin_rise (en_s_ff[1] && !en_d_ff),
      .pin_fall (!en_s_ff[1] && en_d_ff),
      .rise_dly (delay_ff[8*i +: 4]),
      .fall_dly (delay_ff[8*i+4 +: 4]),
      .on_bit   (ctrl_ff[`RCL_CTRL_ON + i]),
      .pin_sel  (ctrl_ff[`RCL_CTRL_PIN + i]),
      .allowed  (state_ff != ST_BOOT),
      .on_ff    (on_w[i])
    );
  end
  assign REG_ON = on_w;

  // ********************
  // bus slave
  // ********************
  // one wait cycle per access: request seen, then answered
  assign take    = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  assign wr_take = AVS_WRITE && !AVS_WAITREQUEST;
  assign ctrl_m  = merge({20'h00000, ctrl_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign delay_m = merge(delay_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign mask_m  = merge({30'h0, mask_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign freq_m  = merge({27'h0, freq_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);

  always_comb begin
    unique case (AVS_ADDRESS)
      `RCL_OFS_CTRL:   rd_w = {20'h00000, ctrl_ff};
      `RCL_OFS_DELAY:  rd_w = delay_ff;
      `RCL_OFS_MSEL:   rd_w = {31'h0, msel_ff};
      `RCL_OFS_RESLO:  rd_w = {24'h0, result_ff[7:0]};
      `RCL_OFS_RESHI:  rd_w = {31'h0, result_ff[8]};
      `RCL_OFS_FLAGS:  rd_w = {30'h0, flag_ff};
      `RCL_OFS_MASK:   rd_w = {30'h0, mask_ff};
      `RCL_OFS_STATUS: rd_w = {22'h0, state_ff, valid, meas_busy_ff, BUCK_PWM, on_w};
      `RCL_OFS_FREQ:   rd_w = {27'h0, freq_ff};
      default:         rd_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST) AVS_READDATA <= rd_w;
    end
  end

  // registers start from their defaults and host may rewrite them
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_ff  <= `RCL_CTRL_RST;
      delay_ff <= `RCL_DELAY_RST;
      mask_ff  <= `RCL_MASK_RST;
      freq_ff  <= `RCL_FREQ_RST;
    end else if (wr_take) begin
      if (AVS_ADDRESS == `RCL_OFS_CTRL) ctrl_ff <= ctrl_m[11:0];
      if (AVS_ADDRESS == `RCL_OFS_DELAY) delay_ff <= delay_m;
      if (AVS_ADDRESS == `RCL_OFS_MASK) mask_ff <= mask_m[1:0];
      if (AVS_ADDRESS == `RCL_OFS_FREQ) freq_ff <= freq_m[4:0];
    end
  end

  // ********************
  // load current measurement
  // ********************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      msel_ff      <= 1'b0;
      meas_busy_ff <= 1'b0;
      meas_cnt_ff  <= 11'h000;
      result_ff    <= 9'h000;
    end else if (wr_take && AVS_ADDRESS == `RCL_OFS_MSEL) begin
      // any write restarts, even mid-sequence
      msel_ff      <= AVS_WRITEDATA[0];
      meas_busy_ff <= 1'b1;
      meas_cnt_ff  <= 11'(`RCL_MEAS_CYC - 1);
    end else if (meas_busy_ff) begin
      meas_cnt_ff <= 11'(meas_cnt_ff - 11'h001);
      if (meas_cnt_ff == 11'h000) begin
        meas_busy_ff <= 1'b0;
        result_ff    <= msel_ff ? ld1_s2_ff : ld0_s2_ff;
      end
    end
  end

  // ********************
  // buck mode
  // ********************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      BUCK_PWM <= 2'h0;
    end else begin
      BUCK_PWM[0] <= ctrl_ff[`RCL_CTRL_FPWM]
                     || (meas_busy_ff && !msel_ff)
                     || (ld0_s2_ff >= 9'(`RCL_PWM_CODE));
      BUCK_PWM[1] <= ctrl_ff[`RCL_CTRL_FPWM + 1]
                     || (meas_busy_ff && msel_ff)
                     || (ld1_s2_ff >= 9'(`RCL_PWM_CODE));
    end
  end

  // ********************
  // clocking
  // ********************
  assign pll_en = ctrl_ff[`RCL_CTRL_PLL];
  assign det_en = pll_en && (state_ff != ST_BOOT);

  rcl_clkdet rcl_clkdet_i (
    .clk      (CLOCK),
    .rst      (RST),
    .en       (pll_en),
    .rise     (sc_s_ff[1] && !sc_d_ff),
    .freq     (freq_ff),
    .valid_ff (valid)
  );

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      valid_d_ff    <= 1'b0;
      CLK_EXT_SEL   <= 1'b0;
      DITHER_ACTIVE <= 1'b0;
    end else begin
      valid_d_ff    <= valid;
      CLK_EXT_SEL   <= pll_en && valid;
      // dither only on the internal oscillator, both cores at once
      DITHER_ACTIVE <= ctrl_ff[`RCL_CTRL_DITH] && !pll_en;
    end
  end

  // ********************
  // flags and interrupt
  // ********************
  assign set_w[0] = meas_busy_ff && (meas_cnt_ff == 11'h000);
  assign set_w[1] = (det_en && (valid != valid_d_ff))
                    || (pll_en && !valid && state_ff == ST_BOOT
                        && boot_ff == 15'(BOOT_CYCLES - 1))
                    || (pll_en && !valid && state_ff == ST_STANDBY
                        && on_w[1:0] != 2'h0);
  assign clr_w = (wr_take && AVS_ADDRESS == `RCL_OFS_FLAGS) ? AVS_WRITEDATA[1:0] : 2'h0;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      flag_ff <= 2'h0;
      IRQ     <= 1'b0;
    end else begin
      // a new event outranks a write-one-to-clear in the same cycle
      flag_ff <= (flag_ff & ~clr_w) | set_w;
      IRQ     <= |(flag_ff & ~mask_ff);
    end
  end

  // ********************
  // checks
  // ********************
  a_meas_start: assert property (@(posedge CLOCK) disable iff (RST)
    wr_take && AVS_ADDRESS == `RCL_OFS_MSEL |=> meas_busy_ff)
    else $error("select write did not start measurement");
  logic [10:0] meas_len_ff;

  // sequence too long for a delay range; count its cycles instead
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      meas_len_ff <= 11'h000;
    end else if (wr_take && AVS_ADDRESS == `RCL_OFS_MSEL) begin
      meas_len_ff <= 11'h001;
    end else if (meas_busy_ff && meas_len_ff != 11'h7ff) begin
      meas_len_ff <= 11'(meas_len_ff + 11'h001);
    end else if (!meas_busy_ff) begin
      meas_len_ff <= 11'h000;
    end
  end

  a_meas_bound: assert property (@(posedge CLOCK) disable iff (RST)
    meas_busy_ff |-> meas_len_ff <= 11'(A_MEAS_MAX))
    else $error("measurement too long");
  a_meas_pwm: assert property (@(posedge CLOCK) disable iff (RST)
    meas_busy_ff |=> BUCK_PWM[$past(msel_ff)])
    else $error("measured buck not in pwm");
  a_meas_flag: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(meas_busy_ff) && !$rose(meas_busy_ff) |-> flag_ff[0])
    else $error("measurement done without flag");
  a_fpwm_hold: assert property (@(posedge CLOCK) disable iff (RST)
    ctrl_ff[`RCL_CTRL_FPWM] |=> BUCK_PWM[0])
    else $error("forced pwm lost");
  a_mask_irq: assert property (@(posedge CLOCK) disable iff (RST)
    mask_ff == 2'h3 |=> !IRQ)
    else $error("masked flag reached interrupt");
  a_dither_pll: assert property (@(posedge CLOCK) disable iff (RST)
    pll_en |=> !DITHER_ACTIVE)
    else $error("dither with external clock");
  a_pll_quiet: assert property (@(posedge CLOCK) disable iff (RST)
    !pll_en && !flag_ff[1] |=> !flag_ff[1])
    else $error("clock flag with pll off");
endmodule

// [tb/rcl_sync_src.sv]
/*
  Far-side sync clock source for the regulator control logic bench.
  Assumes the bench starts and stops it; it idles low when stopped.
*/
`timescale 1ns/1ps

module rcl_sync_src #(
  parameter real HALF_NS = 160.0
) (
  input  wire logic run,
  output logic      sync_out
);
  // ********************
  // clock generation
  // ********************
  // stands still between bursts, like a gated external oscillator
  initial begin
    sync_out = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) begin
        sync_out = ~sync_out;
      end else begin
        sync_out = 1'b0;
      end
    end
  end
endmodule

// [tb/tb_rcl_top.sv]
/*
  Self-checking bench of rcl_top: Avalon-MM master, pins and load codes.
  Assumes short boot and delay step parameters and a 25 MHz clock.
*/
`timescale 1ns/1ps
`include "rcl_defs.svh"

module tb_rcl_top;
  import rcl_pkg::*;
  localparam int STEP = 10;
  logic        CLOCK;
  logic        RST;
  logic [5:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        EN_PIN;
  logic        SYNC_CLOCK_INPUT;
  logic [8:0]  LOAD_CODE0;
  logic [8:0]  LOAD_CODE1;
  logic [3:0]  REG_ON;
  logic [1:0]  BUCK_PWM;
  logic        DITHER_ACTIVE;
  logic        CLK_EXT_SEL;
  logic        IRQ;
  logic        sync_run;
  logic [63:0] expq[$];
  logic [63:0] e;
  logic [31:0] seed;
  logic [8:0]  code;
  int          fail_count;
  int          n_tests;
  int          cyc;

  rcl_top #(.BOOT_CYCLES(20), .STEP_CYCLES(STEP)) rcl_top_i (
    .CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .EN_PIN(EN_PIN),
    .SYNC_CLOCK_INPUT(SYNC_CLOCK_INPUT), .LOAD_CODE0(LOAD_CODE0), .LOAD_CODE1(LOAD_CODE1),
    .REG_ON(REG_ON), .BUCK_PWM(BUCK_PWM), .DITHER_ACTIVE(DITHER_ACTIVE),
    .CLK_EXT_SEL(CLK_EXT_SEL), .IRQ(IRQ));

  rcl_sync_src rcl_sync_src_i (.run(sync_run), .sync_out(SYNC_CLOCK_INPUT));

  // ********************
  // clock, timeout, helpers
  // ********************
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge CLOCK);
  endtask

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic rw, input logic [5:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= rw;
    AVS_WRITE <= ~rw;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] x, input logic [31:0] m);
    expq.push_back({x, m});
    bus(1'b1, a, 32'h0);
  endtask

  // read data checked against the oldest noted expectation
  always @(posedge CLOCK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      e = expq.pop_front();
      chk(AVS_READDATA & e[31:0], e[63:32] & e[31:0], "read data");
    end
  end

  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (IRQ !== 1'b1 && k < lim) begin
      @(posedge CLOCK);
      k++;
    end
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    RST = 1'b1;
    AVS_ADDRESS = 6'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    EN_PIN = 1'b0;
    LOAD_CODE0 = 9'h000;
    LOAD_CODE1 = 9'h000;
    sync_run = 1'b0;
    seed = 32'd25083;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    cyc_n(8);
    RST <= 1'b0;
    cyc_n(30);
    rd(`RCL_OFS_STATUS, 32'h100, 32'h30f);
    rd(`RCL_OFS_CTRL, 32'h0, 32'hffffffff);
    rd(6'h3c, 32'h0, 32'hffffffff);
    $display("test reset done");
    // register enables, pin selects and delays
    wr(`RCL_OFS_CTRL, 32'h0000_000f);
    // on bits land, outputs rise next edge, state follows one edge later
    cyc_n(2);
    rd(`RCL_OFS_STATUS, 32'h20f, 32'h30f);
    wr(`RCL_OFS_DELAY, 32'h0030_0012);
    wr(`RCL_OFS_CTRL, 32'h0000_0055);
    cyc_n(3);
    chk(REG_ON, 4'h0, "pin low keeps off");
    @(posedge CLOCK);
    EN_PIN <= 1'b1;
    cyc_n(6);
    chk(REG_ON, 4'h4, "code 0 on, code 2 waits");
    cyc_n(2 * STEP + 4);
    chk(REG_ON, 4'h5, "both on after start delay");
    EN_PIN <= 1'b0;
    cyc_n(6);
    chk(REG_ON[2], 1'b1, "linear waits shutdown");
    cyc_n(STEP + 6);
    chk(REG_ON[0], 1'b0, "buck off after one step");
    cyc_n(2 * STEP);
    chk(REG_ON, 4'h0, "all off");
    wr(`RCL_OFS_CTRL, 32'h0000_0005);
    cyc_n(2);
    chk(REG_ON, 4'h5, "register write without delay");
    @(posedge CLOCK);
    EN_PIN <= 1'b1;
    wr(`RCL_OFS_CTRL, 32'h0000_0050);
    cyc_n(2);
    chk(REG_ON, 4'h0, "on bit low forces off");
    $display("test enables done");
    // mode choice
    LOAD_CODE0 <= 9'd29;
    cyc_n(6);
    chk(BUCK_PWM[0], 1'b0, "light load PFM");
    LOAD_CODE0 <= 9'd30;
    cyc_n(6);
    chk(BUCK_PWM[0], 1'b1, "600 mA PWM");
    wr(`RCL_OFS_CTRL, 32'h0000_0200);
    cyc_n(3);
    chk(BUCK_PWM[1], 1'b1, "forced PWM");
    $display("test mode done");
    // load measurement, unmasked then masked
    seed = xs(seed);
    code = seed[8:0];
    LOAD_CODE1 <= code;
    wr(`RCL_OFS_CTRL, 32'h0000_0000);
    cyc_n(6);
    wr(`RCL_OFS_MSEL, 32'h1);
    rd(`RCL_OFS_STATUS, 32'h60, 32'h60);
    wait_irq(1260);
    chk(IRQ, 1'b1, "measure done interrupt");
    rd(`RCL_OFS_RESLO, {24'h0, code[7:0]}, 32'hff);
    rd(`RCL_OFS_RESHI, {31'h0, code[8]}, 32'h1);
    wr(`RCL_OFS_FLAGS, 32'h3);
    cyc_n(3);
    chk(IRQ, 1'b0, "flag cleared");
    wr(`RCL_OFS_MASK, 32'h1);
    wr(`RCL_OFS_MSEL, 32'h0);
    cyc_n(1300);
    chk(IRQ, 1'b0, "masked measure");
    rd(`RCL_OFS_FLAGS, 32'h1, 32'h1);
    $display("test measure done");
    // dither gating
    wr(`RCL_OFS_CTRL, 32'h0000_0400);
    cyc_n(3);
    chk(DITHER_ACTIVE, 1'b1, "dither on");
    wr(`RCL_OFS_CTRL, 32'h0000_0c00);
    cyc_n(3);
    chk(DITHER_ACTIVE, 1'b0, "dither off with PLL");
    $display("test dither done");
    // sync clock detection at about 3.1 MHz
    wr(`RCL_OFS_FREQ, 32'h2);
    wr(`RCL_OFS_MASK, 32'h0);
    wr(`RCL_OFS_FLAGS, 32'h3);
    sync_run = 1'b1;
    cyc_n(700);
    chk(CLK_EXT_SEL, 1'b1, "external clock taken");
    chk(IRQ, 1'b1, "clock appears");
    wr(`RCL_OFS_FLAGS, 32'h2);
    wr(`RCL_OFS_MASK, 32'h3);
    wr(`RCL_OFS_FREQ, 32'h0);
    cyc_n(700);
    chk(CLK_EXT_SEL, 1'b0, "out of range clock");
    chk(IRQ, 1'b0, "sync masked");
    rd(`RCL_OFS_FLAGS, 32'h2, 32'h2);
    sync_run = 1'b0;
    wr(`RCL_OFS_FLAGS, 32'h2);
    wr(`RCL_OFS_CTRL, 32'h0000_0801);
    cyc_n(4);
    rd(`RCL_OFS_FLAGS, 32'h2, 32'h2);
    $display("test sync done");
    summarize();
  end
endmodule
